//--- common/spp_pkg.sv
// Constants and carrier types for the serial peripheral port
package spp_pkg;
  localparam logic [3:0] SPP_OFS_STAT = 4'h0;
  localparam logic [3:0] SPP_OFS_CON1 = 4'h4;
  localparam logic [3:0] SPP_OFS_CON2 = 4'h8;
  localparam logic [3:0] SPP_OFS_BUF = 4'hC;
  localparam logic [15:0] SPP_RST_VAL = 16'h0000;
  localparam logic [15:0] SPP_STAT_WMASK = 16'hA000;
  localparam logic [15:0] SPP_CON1_WMASK = 16'h1FFF;
  localparam logic [15:0] SPP_CON2_WMASK = 16'hE002;
  localparam logic [15:0] SPP_FULL_MASK = 16'hFFFF;
  localparam int SPP_ENABLE = 15;
  localparam int SPP_STOP_IDLE = 13;
  localparam int SPP_OVERFLOW = 6;
  localparam int SPP_TX_FULL = 1;
  localparam int SPP_RX_FULL = 0;
  localparam int SPP_CLK_DIS = 12;
  localparam int SPP_OUT_DIS = 11;
  localparam int SPP_WIDE = 10;
  localparam int SPP_SAMPLE = 9;
  localparam int SPP_EDGE = 8;
  localparam int SPP_SEL_EN = 7;
  localparam int SPP_POLARITY = 6;
  localparam int SPP_MASTER = 5;
  localparam int SPP_SEC_LSB = 2;
  localparam int SPP_PRI_LSB = 0;
  localparam int SPP_FRAMED = 15;
  localparam int SPP_FS_DIR = 14;
  localparam int SPP_FS_POL = 13;
  localparam int SPP_FS_EDGE = 1;
  localparam logic [4:0] SPP_BITS_WIDE = 5'h10;
  localparam logic [4:0] SPP_BITS_BYTE = 5'h08;
  localparam logic [3:0] SPP_SEC_BASE = 4'h8;
  localparam logic [5:0] SPP_FRAME_TICKS = 6'h2;
  typedef struct packed {
    logic shift_clk;
    logic data_in;
    logic slave_sel_n;
  } spp_pin_in_s;
  typedef struct packed {
    logic shift_clk_o;
    logic shift_clk_oe;
    logic data_out_o;
    logic data_out_oe;
    logic slave_sel_o;
    logic slave_sel_oe;
  } spp_pin_out_s;
  typedef enum logic [1:0] {
    SPP_IDLE,
    SPP_FRAME,
    SPP_SHIFT
  } spp_state_e;
endpackage

//--- rtl/spp_port.sv
// Serial peripheral port: register slave, shift engine and pin control
`timescale 1ns/100ps
// Summary of operation
// - One 16-bit shift register moves data; software exchanges words via a buffer.
// - Master drives the shift clock pin; slave takes it as input.
// - Enable bit hands the pins to the port; clear disables it.
// - Stop-in-idle set freezes the port while the processor idles.
// - Word finishing while receive buffer unread is discarded and sets overflow.
// - Transmit full sets on buffer write, clears when loaded into shifter.
// - Receive full sets when a word lands, clears on buffer read.
// - Clock pin disable stops the master clock and frees the pin.
// - Data out disable frees the data output pin.
// - Word size select picks 16-bit or 8-bit transfers.
// - Master samples input at end or middle of output time.
// - Outside framed mode, clock edge select picks which clock transition changes output data.
// - Clock polarity sets the idle and active clock levels.
// - Outside framed mode, slave select enable makes the slave obey the active-low select pin.
// - Master enable picks master or slave operation.
// - Master clock divides by primary and secondary prescalers.
// - Framed mode uses the select pin as frame sync.
// - Sync direction makes frame sync an input or, in master mode only, a driven output.
// - Sync polarity makes the frame pulse active high or low.
// - Sync edge makes the pulse coincide with or precede the first bit.
module spp_port (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_idle,
  input spp_pkg::spp_pin_in_s pin_in,
  output spp_pkg::spp_pin_out_s pin_out
);
  import spp_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  logic [15:0] stat_reg;
  logic [15:0] con1_reg;
  logic [15:0] con2_reg;
  logic [15:0] tx_buf_reg;
  logic [15:0] rx_buf_reg;
  logic [15:0] sr_reg;
  logic tx_full_reg;
  logic rx_full_reg;
  logic overflow_reg;
  spp_state_e state_reg;
  logic [5:0] tick_t;
  logic [9:0] div_cnt;
  logic [4:0] bcnt;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic clk_prev;
  logic fs_prev;

  logic bus_req;
  logic bus_done;
  logic wr_stat;
  logic wr_con1;
  logic wr_con2;
  logic wr_buf;
  logic rd_buf;
  logic [15:0] stat_view;

  // Byte-lane merge, writable bits only
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    for (int i = 0; i < 2; i++) begin
      if (avs_byteenable[i]) begin
        res[i*8 +: 8] = (old[i*8 +: 8] & ~mask[i*8 +: 8]) | (avs_writedata[i*8 +: 8] & mask[i*8 +: 8]);
      end
    end
    return res;
  endfunction

  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~avs_waitrequest;
  assign wr_stat = bus_done & avs_write & (avs_address == SPP_OFS_STAT);
  assign wr_con1 = bus_done & avs_write & (avs_address == SPP_OFS_CON1);
  assign wr_con2 = bus_done & avs_write & (avs_address == SPP_OFS_CON2);
  assign wr_buf = bus_done & avs_write & (avs_address == SPP_OFS_BUF);
  assign rd_buf = bus_done & avs_read & (avs_address == SPP_OFS_BUF);

  // One wait cycle per access; idle level is high
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  always_comb begin
    stat_view = stat_reg & SPP_STAT_WMASK;
    stat_view[SPP_OVERFLOW] = overflow_reg;
    stat_view[SPP_TX_FULL] = tx_full_reg;
    stat_view[SPP_RX_FULL] = rx_full_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (bus_req & avs_waitrequest) begin
      unique case (avs_address)
        SPP_OFS_STAT: avs_readdata <= {16'h0000, stat_view};
        SPP_OFS_CON1: avs_readdata <= {16'h0000, con1_reg};
        SPP_OFS_CON2: avs_readdata <= {16'h0000, con2_reg};
        SPP_OFS_BUF: avs_readdata <= {16'h0000, rx_buf_reg};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_reg <= SPP_RST_VAL;
      con1_reg <= SPP_RST_VAL;
      con2_reg <= SPP_RST_VAL;
    end else begin
      if (wr_stat) begin
        stat_reg <= wmerge(stat_reg, SPP_STAT_WMASK);
      end
      if (wr_con1) begin
        con1_reg <= wmerge(con1_reg, SPP_CON1_WMASK);
      end
      if (wr_con2) begin
        con2_reg <= wmerge(con2_reg, SPP_CON2_WMASK);
      end
    end
  end

  logic port_enable;
  logic stop_in_idle;
  logic clock_pin_disable;
  logic data_out_disable;
  logic word_size_select;
  logic sample_phase;
  logic slave_select_enable;
  logic clock_polarity;
  logic master_enable;
  logic framed_mode_enable;
  logic frame_sync_direction;
  logic frame_sync_polarity;
  logic frame_sync_edge;
  logic run;
  logic edge_eff;
  logic sel_gate;
  logic fs_input;
  logic frame_pre;
  logic [4:0] nbits;
  logic [5:0] n_ticks;

  assign port_enable = stat_reg[SPP_ENABLE];
  assign stop_in_idle = stat_reg[SPP_STOP_IDLE];
  assign clock_pin_disable = con1_reg[SPP_CLK_DIS];
  assign data_out_disable = con1_reg[SPP_OUT_DIS];
  assign word_size_select = con1_reg[SPP_WIDE];
  assign sample_phase = con1_reg[SPP_SAMPLE];
  assign slave_select_enable = con1_reg[SPP_SEL_EN];
  assign clock_polarity = con1_reg[SPP_POLARITY];
  assign master_enable = con1_reg[SPP_MASTER];
  assign framed_mode_enable = con2_reg[SPP_FRAMED];
  assign frame_sync_direction = con2_reg[SPP_FS_DIR];
  assign frame_sync_polarity = con2_reg[SPP_FS_POL];
  assign frame_sync_edge = con2_reg[SPP_FS_EDGE];

  assign run = port_enable & ~(stop_in_idle & cpu_idle);
  assign edge_eff = con1_reg[SPP_EDGE] & ~framed_mode_enable;
  assign sel_gate = slave_select_enable & ~framed_mode_enable;
  assign fs_input = framed_mode_enable & frame_sync_direction;
  assign frame_pre = framed_mode_enable & ~frame_sync_direction & ~frame_sync_edge;
  assign nbits = word_size_select ? SPP_BITS_WIDE : SPP_BITS_BYTE;
  assign n_ticks = {nbits, 1'b0};

  // Pin inputs: meta stage feeds only the sync stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_meta <= 3'h1;
      pin_sync <= 3'h1;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  logic sck_s;
  logic sdi_s;
  logic ss_s;
  logic lead;
  logic trail;
  logic fs_act;
  logic fs_start;

  assign sck_s = pin_sync[2];
  assign sdi_s = pin_sync[1];
  assign ss_s = pin_sync[0];
  assign lead = (sck_s ^ clock_polarity) & ~(clk_prev ^ clock_polarity);
  assign trail = ~(sck_s ^ clock_polarity) & (clk_prev ^ clock_polarity);
  assign fs_act = ss_s == frame_sync_polarity;
  assign fs_start = fs_act & ~fs_prev;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_prev <= 1'b0;
      fs_prev <= 1'b0;
    end else begin
      clk_prev <= sck_s;
      fs_prev <= fs_act;
    end
  end

  logic [6:0] pri_f;
  logic [3:0] sec_f;
  logic [10:0] div_prod;
  logic [9:0] half_a;
  logic [9:0] half_b;
  logic [9:0] half_len;
  logic tick;

  // prescaler product sets the bit period
  assign pri_f = 7'h01 << {~con1_reg[SPP_PRI_LSB +: 2], 1'b0};
  assign sec_f = SPP_SEC_BASE - {1'b0, con1_reg[SPP_SEC_LSB +: 3]};
  assign div_prod = pri_f * sec_f;
  // forbidden 1:1 still yields a legal half period
  assign half_a = (div_prod[10:1] == 10'h000) ? 10'h001 : div_prod[10:1];
  assign half_b = 10'(div_prod - {1'b0, div_prod[10:1]});
  assign half_len = tick_t[0] ? half_b : half_a;
  assign tick = (state_reg != SPP_IDLE) & run & ~clock_pin_disable
                & (div_cnt == 10'(half_len - 10'h001));

  always_ff @(posedge clk_sys) begin
    if (srst | ~port_enable | (state_reg == SPP_IDLE) | tick) begin
      div_cnt <= 10'h000;
    end else if (run & ~clock_pin_disable) begin
      div_cnt <= 10'(div_cnt + 10'h001);
    end
  end

  logic in_shift;
  logic is_last;
  logic at_mid;
  logic at_end;
  logic m_samp;
  logic m_chg;
  logic m_done;
  logic m_load;
  logic s_live;
  logic s_samp;
  logic s_chg;
  logic s_done;
  logic s_load;
  logic load_now;
  logic samp_now;
  logic chg_now;
  logic done_now;
  logic [15:0] sr_shift;
  logic [15:0] rx_word;
  logic accept;

  assign in_shift = state_reg == SPP_SHIFT;
  assign is_last = tick_t == n_ticks;
  assign at_mid = (tick_t[0] != edge_eff) & ~is_last;
  assign at_end = (tick_t[0] == edge_eff) & (tick_t != 6'h00);
  assign m_samp = tick & in_shift & (sample_phase ? at_end : at_mid);
  assign m_chg = tick & in_shift & (tick_t[0] == edge_eff) & (tick_t < 6'(n_ticks - 6'h01));
  assign m_done = tick & in_shift & is_last;
  // master starts from a full transmit buffer
  assign m_load = (state_reg == SPP_IDLE) & run & master_enable & tx_full_reg
                  & ~clock_pin_disable & (~fs_input | fs_start);
  assign s_live = run & ~master_enable & (~sel_gate | ~ss_s);
  // slave changes on the other edge from sampling
  assign s_samp = s_live & (edge_eff ? lead : trail);
  assign s_chg = s_live & (edge_eff ? trail : lead);
  assign s_done = s_samp & (bcnt == 5'(nbits - 5'h01));
  assign s_load = run & ~master_enable & tx_full_reg & (bcnt == 5'h00) & ~s_samp;
  assign load_now = m_load | s_load;
  assign samp_now = m_samp | s_samp;
  assign chg_now = m_chg | s_chg;
  assign done_now = m_done | s_done;
  assign sr_shift = {sr_reg[14:0], sdi_s};
  // Last sample may land on the completing tick
  assign rx_word = samp_now ? sr_shift : sr_reg;
  assign accept = done_now & (~rx_full_reg | rd_buf);

  always_ff @(posedge clk_sys) begin
    if (srst | ~port_enable) begin
      state_reg <= SPP_IDLE;
      tick_t <= 6'h00;
    end else begin
      unique case (state_reg)
        SPP_IDLE: begin
          tick_t <= 6'h00;
          if (m_load) begin
            state_reg <= frame_pre ? SPP_FRAME : SPP_SHIFT;
          end
        end
        SPP_FRAME: begin
          if (tick & (tick_t == SPP_FRAME_TICKS - 6'h01)) begin
            state_reg <= SPP_SHIFT;
            tick_t <= 6'h00;
          end else if (tick) begin
            tick_t <= 6'(tick_t + 6'h01);
          end
        end
        SPP_SHIFT: begin
          if (m_done) begin
            // Clear count here so a halt right after completion sees it settled
            state_reg <= SPP_IDLE;
            tick_t <= 6'h00;
          end else if (tick) begin
            tick_t <= 6'(tick_t + 6'h01);
          end
        end
        default: state_reg <= SPP_IDLE;
      endcase
    end
  end

  // Slave bit count restarts on deselect or frame start
  always_ff @(posedge clk_sys) begin
    if (srst | ~port_enable | s_done) begin
      bcnt <= 5'h00;
    end else if (s_samp) begin
      bcnt <= 5'(bcnt + 5'h01);
    end else if (run & (master_enable | (sel_gate & ss_s) | (fs_input & fs_start))) begin
      bcnt <= 5'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sr_reg <= SPP_RST_VAL;
    end else if (load_now) begin
      sr_reg <= tx_buf_reg;
    end else if (samp_now) begin
      sr_reg <= sr_shift;
    end
  end

  logic frame_on;
  assign frame_on = (state_reg == SPP_FRAME)
                    | (framed_mode_enable & frame_sync_edge & in_shift & (tick_t < SPP_FRAME_TICKS));

  always_ff @(posedge clk_sys) begin
    if (srst | ~port_enable) begin
      pin_out <= '0;
    end else begin
      pin_out.shift_clk_oe <= master_enable & ~clock_pin_disable;
      if (state_reg == SPP_IDLE) begin
        pin_out.shift_clk_o <= clock_polarity;
      end else if (tick & in_shift & ~is_last) begin
        pin_out.shift_clk_o <= ~pin_out.shift_clk_o;
      end
      pin_out.data_out_oe <= ~data_out_disable & (master_enable | ~sel_gate | ~ss_s);
      if (load_now) begin
        pin_out.data_out_o <= word_size_select ? tx_buf_reg[15] : tx_buf_reg[7];
      end else if (chg_now) begin
        pin_out.data_out_o <= samp_now ? (word_size_select ? sr_reg[14] : sr_reg[6])
                                       : (word_size_select ? sr_reg[15] : sr_reg[7]);
      end
      // select pin becomes frame sync output
      pin_out.slave_sel_oe <= framed_mode_enable & ~frame_sync_direction & master_enable;
      pin_out.slave_sel_o <= frame_on ? frame_sync_polarity : ~frame_sync_polarity;
    end
  end

  // Flags: a hardware set wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_full_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      overflow_reg <= 1'b0;
      tx_buf_reg <= SPP_RST_VAL;
      rx_buf_reg <= SPP_RST_VAL;
    end else begin
      if (wr_buf) begin
        tx_full_reg <= 1'b1;
        tx_buf_reg <= wmerge(tx_buf_reg, SPP_FULL_MASK);
      end else if (load_now) begin
        tx_full_reg <= 1'b0;
      end
      if (accept) begin
        rx_full_reg <= 1'b1;
        rx_buf_reg <= word_size_select ? rx_word : {8'h00, rx_word[7:0]};
      end else if (rd_buf) begin
        rx_full_reg <= 1'b0;
      end
      if (done_now & ~accept) begin
        overflow_reg <= 1'b1;
      end else if (wr_stat & avs_byteenable[0] & ~avs_writedata[SPP_OVERFLOW]) begin
        overflow_reg <= 1'b0;
      end
    end
  end

  a_tbf_set_write: assert property (wr_buf |=> tx_full_reg)
    else $error("transmit full not set by write");
  a_tbf_clear_load: assert property (load_now && !wr_buf |=> !tx_full_reg)
    else $error("transmit full not cleared by load");
  a_rbf_accept: assert property (done_now && !rx_full_reg |=> rx_full_reg)
    else $error("receive full not set on completion");
  a_rbf_read_clr: assert property (rd_buf && !done_now |=> !rx_full_reg)
    else $error("receive full not cleared by read");
  a_ovf_discard: assert property (done_now && rx_full_reg && !rd_buf
    |=> overflow_reg && $stable(rx_buf_reg))
    else $error("overflow word not discarded");
  a_idle_halt: assert property (port_enable && !run
    |=> $stable(sr_reg) && $stable(tick_t) && $stable(bcnt))
    else $error("port moved while halted");
  a_master_clk_oe: assert property (port_enable && master_enable && !clock_pin_disable
    |=> pin_out.shift_clk_oe)
    else $error("master clock pin not driven");
  a_slave_clk_in: assert property (!master_enable |=> !pin_out.shift_clk_oe)
    else $error("slave drives clock pin");
  a_disable_pins: assert property (!port_enable |=> pin_out == '0)
    else $error("disabled port drives pins");
  a_sdo_release: assert property (data_out_disable |=> !pin_out.data_out_oe)
    else $error("data pin driven while disabled");
  a_clk_idle_lvl: assert property (port_enable && state_reg == SPP_IDLE
    |=> pin_out.shift_clk_o == $past(clock_polarity))
    else $error("clock not at idle level");

  c_master_word: cover property (m_done && word_size_select);
  c_slave_byte: cover property (s_done && !word_size_select);
  c_overflow: cover property (done_now && !accept);
  c_framed: cover property (state_reg == SPP_FRAME ##1 state_reg == SPP_SHIFT);
endmodule

//--- tb/spp_link_partner.sv
// Behavioural far-side device that shifts one word against the port
`timescale 1ns/100ps
module spp_link_partner (
  input wire logic port_clk,
  input wire logic port_dout,
  output logic sck,
  output logic sel_n,
  output logic dout
);
  logic is_master;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  int nbits;
  int lead_cnt;
  wire logic eff_clk;
  assign eff_clk = is_master ? sck : port_clk;
  initial begin
    is_master = 1'b0;
    sck = 1'b0;
    sel_n = 1'b1;
    dout = 1'b0;
    tx_word = 16'h0000;
    rx_word = 16'h0000;
    nbits = 8;
    lead_cnt = 0;
  end
  always @(posedge eff_clk) begin
    if (lead_cnt < nbits) dout = tx_word[nbits - 1 - lead_cnt];
    lead_cnt++;
  end
  always @(negedge eff_clk) rx_word = {rx_word[14:0], port_dout};
  task automatic prime(input logic [15:0] w, input int n);
    tx_word = w;
    nbits = n;
    lead_cnt = 0;
    rx_word = 16'h0000;
  endtask
  task automatic master_frame(input int clocks);
    is_master = 1'b1;
    sel_n = 1'b0;
    #170;
    repeat (clocks) begin
      sck = 1'b1;
      #200;
      sck = 1'b0;
      #200;
    end
    #170;
    sel_n = 1'b1;
    // Released line must not keep the last bit
    dout = ~dout;
    is_master = 1'b0;
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module tb_top;
  import spp_pkg::*;
  logic clk_sys, srst, avs_read, avs_write, cpu_idle, avs_waitrequest, sck, sel_n, din;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] rd;
  logic [3:0] ofs [3] = '{SPP_OFS_STAT, SPP_OFS_CON1, SPP_OFS_CON2};
  logic [15:0] wm [3] = '{SPP_STAT_WMASK, SPP_CON1_WMASK, SPP_CON2_WMASK};
  logic [15:0] psc [5] = '{16'h001B, 16'h001E, 16'h001D, 16'h001C, 16'h0003};
  int per [5] = '{2, 4, 16, 64, 8};
  int miscompares, check_count, n;
  spp_pin_in_s pin_in;
  spp_pin_out_s pin_out;
  assign pin_in = '{shift_clk: sck, data_in: din, slave_sel_n: sel_n};
  spp_port dut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_idle(cpu_idle), .pin_in(pin_in),
    .pin_out(pin_out));
  spp_link_partner link (.port_clk(pin_out.shift_clk_o), .port_dout(pin_out.data_out_o),
    .sck(sck), .sel_n(sel_n), .dout(din));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[15:0];
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Poll status until a flag rises, bounded
  task automatic wait_bit(input int b);
    int k;
    k = 0;
    do begin
      bus_rd(SPP_OFS_STAT, rd);
      k++;
    end while (rd[b] !== 1'b1 && k < 400);
  endtask
  task automatic wait_clk(input logic v);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      n++;
      k++;
    end while (pin_out.shift_clk_o !== v && k < 200);
  endtask
  initial begin
    #3000000;
    miscompares++;
    print_verdict();
  end
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    cpu_idle = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      bus_rd(ofs[i], rd);
      `CHK(rd, 16'h0000)
      bus_wr(ofs[i], 16'hFFFF, 4'h3);
      bus_rd(ofs[i], rd);
      `CHK(rd, wm[i])
      bus_wr(ofs[i], 16'h0000, 4'h3);
    end
    bus_wr(4'h2, 16'h1234, 4'h3);
    bus_rd(4'h2, rd);
    `CHK(rd, 16'h0000)
    `CHK(pin_out, 6'h00)
    // Held by clock disable, then by idle halt
    bus_wr(SPP_OFS_CON1, 16'h103D, 4'h3);
    bus_wr(SPP_OFS_STAT, 16'hA000, 4'h3);
    cpu_idle <= 1'b1;
    link.prime(16'h003C, 8);
    bus_wr(SPP_OFS_BUF, 16'h00A5, 4'h3);
    repeat (300) @(posedge clk_sys);
    `CHK(pin_out.shift_clk_oe, 1'b0)
    bus_rd(SPP_OFS_STAT, rd);
    `CHK(rd, 16'hA002)
    bus_wr(SPP_OFS_CON1, 16'h003D, 4'h3);
    repeat (300) @(posedge clk_sys);
    bus_rd(SPP_OFS_STAT, rd);
    `CHK(rd, 16'hA002)
    cpu_idle <= 1'b0;
    wait_bit(SPP_RX_FULL);
    `CHK(rd, 16'hA001)
    `CHK(link.rx_word[7:0], 8'hA5)
    bus_rd(SPP_OFS_BUF, rd);
    `CHK(rd, 16'h003C)
    bus_rd(SPP_OFS_STAT, rd);
    `CHK(rd, 16'hA000)
    // Second word lands on an unread buffer
    link.prime(16'h005A, 8);
    bus_wr(SPP_OFS_BUF, 16'h0011, 4'h3);
    wait_bit(SPP_RX_FULL);
    link.prime(16'h0069, 8);
    bus_wr(SPP_OFS_BUF, 16'h0022, 4'h3);
    wait_bit(SPP_OVERFLOW);
    `CHK(rd, 16'hA041)
    bus_rd(SPP_OFS_BUF, rd);
    `CHK(rd, 16'h005A)
    bus_wr(SPP_OFS_STAT, 16'h0000, 4'h1);
    bus_rd(SPP_OFS_STAT, rd);
    `CHK(rd, 16'hA000)
    bus_wr(SPP_OFS_CON1, 16'h043D, 4'h3);
    link.prime(16'h5A0F, 16);
    bus_wr(SPP_OFS_BUF, 16'hC3A5, 4'h3);
    wait_bit(SPP_RX_FULL);
    bus_rd(SPP_OFS_BUF, rd);
    `CHK(rd, 16'h5A0F)
    `CHK(link.rx_word, 16'hC3A5)
    // Table never pairs both 1:1 settings
    for (int i = 0; i < 5; i++) begin
      bus_wr(SPP_OFS_CON1, 16'h0020 | psc[i], 4'h3);
      link.prime(16'h0000, 8);
      bus_wr(SPP_OFS_BUF, 16'h0000, 4'h3);
      wait_clk(1'b0);
      wait_clk(1'b1);
      n = 0;
      wait_clk(1'b0);
      wait_clk(1'b1);
      `CHK(n, per[i])
      wait_bit(SPP_RX_FULL);
      bus_rd(SPP_OFS_BUF, rd);
    end
    bus_wr(SPP_OFS_CON1, 16'h007D, 4'h3);
    repeat (4) @(posedge clk_sys);
    `CHK(pin_out.shift_clk_o, 1'b1)
    `CHK(pin_out.shift_clk_oe, 1'b1)
    bus_wr(SPP_OFS_STAT, 16'h0000, 4'h3);
    bus_wr(SPP_OFS_CON1, 16'h0080, 4'h3);
    bus_wr(SPP_OFS_STAT, 16'h8000, 4'h3);
    repeat (2) @(posedge clk_sys);
    `CHK(pin_out.shift_clk_oe, 1'b0)
    bus_wr(SPP_OFS_BUF, 16'h0096, 4'h3);
    link.prime(16'h004B, 8);
    link.master_frame(3);
    @(posedge clk_sys);
    bus_wr(SPP_OFS_BUF, 16'h0096, 4'h3);
    link.prime(16'h004B, 8);
    link.master_frame(8);
    @(posedge clk_sys);
    wait_bit(SPP_RX_FULL);
    bus_rd(SPP_OFS_BUF, rd);
    `CHK(rd, 16'h004B)
    `CHK(link.rx_word[7:0], 8'h96)
    // Framed setup keeps edge and select enable clear
    bus_wr(SPP_OFS_STAT, 16'h0000, 4'h3);
    bus_wr(SPP_OFS_CON1, 16'h083D, 4'h3);
    bus_wr(SPP_OFS_CON2, 16'hA000, 4'h3);
    bus_wr(SPP_OFS_STAT, 16'h8000, 4'h3);
    link.prime(16'h0000, 8);
    bus_wr(SPP_OFS_BUF, 16'h0055, 4'h3);
    n = 0;
    while (pin_out.slave_sel_o !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n < 200, 1'b1)
    `CHK(pin_out.shift_clk_o, 1'b0)
    `CHK(pin_out.slave_sel_oe, 1'b1)
    `CHK(pin_out.data_out_oe, 1'b0)
    wait_bit(SPP_RX_FULL);
    `CHK(rd[SPP_RX_FULL], 1'b1)
    bus_wr(SPP_OFS_STAT, 16'h0000, 4'h3);
    repeat (4) @(posedge clk_sys);
    `CHK(pin_out, 6'h00)
    print_verdict();
  end
endmodule
